// *** sas_pkg.sv ***
// Purpose: Shared constants and types of the converter sequencer.
// Assumes: One state of the converter is one pclk cycle.
// Notes:   Register offsets are byte addresses on the APB bus.
package sas_pkg;
  localparam int unsigned RES_BITS      = 10;
  localparam int unsigned NUM_CH        = 8;
  localparam logic [7:0]  OFS_CSR       = 8'h00;
  localparam logic [7:0]  OFS_TRG       = 8'h04;
  localparam logic [7:0]  OFS_EDGE      = 8'h08;
  localparam logic [7:0]  OFS_DATA0     = 8'h0C;
  localparam logic [7:0]  OFS_DATA_LAST = 8'h28;
  localparam int unsigned CSR_FLAG_POS  = 7;
  localparam int unsigned CSR_IRQ_POS   = 6;
  localparam int unsigned CSR_START_POS = 5;
  localparam int unsigned CSR_SCAN_POS  = 4;
  localparam int unsigned CSR_SPEED_POS = 3;
  localparam int unsigned TRG_EN_POS    = 7;
  localparam int unsigned TRG_RSV0_POS  = 0;
  localparam int unsigned EDGE_SEL_POS  = 0;
  localparam logic [7:0]  CSR_RST       = 8'h00;
  localparam logic [7:0]  TRG_RSVD_ONES = 8'h7E;
  localparam logic        TRG_EN_RST    = 1'b0;
  localparam logic        TRG_RSV0_RST  = 1'b0;
  localparam logic        EDGE_SEL_RST  = 1'b0;
  localparam logic [6:0]  DLY_SLOW_MIN  = 7'h06;
  localparam logic [6:0]  DLY_FAST_MIN  = 7'h04;
  localparam logic [6:0]  SPL_SLOW      = 7'h1F;
  localparam logic [6:0]  SPL_FAST      = 7'h0F;
  localparam logic [6:0]  CONV_SLOW     = 7'h5E;
  localparam logic [6:0]  CONV_FAST     = 7'h32;
  localparam logic [6:0]  GAP_SLOW      = 7'h03;
  localparam logic [6:0]  GAP_FAST      = 7'h01;
  localparam logic [3:0]  STEP_SLOW     = 4'h9;
  localparam logic [3:0]  STEP_FAST     = 4'h4;

  typedef struct packed {
    logic       end_flag;
    logic       irq_en;
    logic       start;
    logic       scan;
    logic       speed;
    logic [2:0] chan;
  } sas_csr_t;

  typedef enum logic [4:0] {
    SAS_IDLE   = 5'b00001,
    SAS_DELAY  = 5'b00010,
    SAS_SAMPLE = 5'b00100,
    SAS_CONV   = 5'b01000,
    SAS_GAP    = 5'b10000
  } sas_state_t;

  function automatic logic [6:0] sas_pick(input logic fast, input logic [6:0] slow_v, input logic [6:0] fast_v);
    sas_pick = fast ? fast_v : slow_v;
  endfunction : sas_pick

  function automatic logic [2:0] sas_first(input logic scan, input logic [2:0] chan);
    sas_first = scan ? {chan[2], 2'b00} : chan;
  endfunction : sas_first
endpackage : sas_pkg

// *** sas_trig.sv ***
// Purpose: Edge detector for the external conversion trigger pin.
// Assumes: The pin is already synchronous to pclk.
// Notes:   The pin is taken as idle high, so reset does not fake an edge.
`timescale 1ns/1ns
module sas_trig
  import sas_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  input  wire logic enable,
  input  wire logic rise_sel,
  output logic      fire
);
  logic prev_q;
  logic fire_q;
  wire  rise_w = pin & ~prev_q;
  wire  fall_w = ~pin & prev_q;
  wire  fire_d = enable & (rise_sel ? rise_w : fall_w);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q <= 1'b1;
      fire_q <= 1'b0;
    end
    else
    begin
      prev_q <= pin;
      fire_q <= fire_d;
    end
  end

  assign fire = fire_q;
endmodule : sas_trig

// *** sas_sar.sv ***
// Purpose: Successive approximation register feeding the comparator.
// Assumes: keep is high when the input is at or above the trial code.
// Notes:   One decision per step, most significant bit first.
`timescale 1ns/1ns
module sas_sar
  import sas_pkg::*;
#(
  parameter int unsigned W = RES_BITS
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic         step,
  input  wire logic         keep,
  output logic [W-1:0]      code
);
  localparam logic [W-1:0] MSB = {1'b1, {(W-1){1'b0}}};
  logic [W-1:0] code_q;
  logic [W-1:0] mask_q;
  wire  [W-1:0] kept_w = keep ? code_q : (code_q & ~mask_q);
  wire  [W-1:0] next_m = mask_q >> 1;

  if (W < 2)
  begin : g_chk
    $error("sas_sar needs at least two bits");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_q <= '0;
      mask_q <= '0;
    end
    else if (load)
    begin
      code_q <= MSB;
      mask_q <= MSB;
    end
    else if (step)
    begin
      code_q <= kept_w | next_m;
      mask_q <= next_m;
    end
  end

  assign code = code_q;
endmodule : sas_sar

// *** sas_top.sv ***
// Purpose: Sequencer of an eight input successive approximation converter.
// Assumes: APB slave, one pclk cycle per converter state, inputs synchronous.
// Notes:   Every access takes one wait state; outputs come from flip-flops.
// Contract
// RQ1: Single mode converts the one input named by the channel field.
// RQ2: Scan mode converts a group; low channel bits give the last input.
// RQ3: A scan starts at input 0 or 4 by the top channel bit.
// RQ4: The trigger pin starts only while trigger enable is set; resets clear.
// RQ5: The chosen pin edge sets the start bit; falling edge by default.
// RQ6: A triggered start behaves exactly like a software start.
// RQ7: Trigger register bits 6 to 1 ignore writes and read as one.
// RQ8: Software keeps trigger register bit 0 at zero; it stays writable.
// RQ9: Software clears the start bit before changing mode or channels.
// RQ10: One write may set start and change mode; new settings apply.
// RQ11: Each result has ten bits found by successive approximation.
// RQ12: Each channel result goes to that channel's data register.
// RQ13: Single mode end sets the end flag; irq follows if enabled.
// RQ14: Single mode holds start during conversion, then clears it, idles.
// RQ15: Scan group end sets the flag, irq if enabled, restarts group.
// RQ16: Scan never clears start itself; it stops when software clears.
// RQ17: Start delay is 6 to 9 states slow, 4 to 5 fast.
// RQ18: Sampling holds 31 states slow, 15 fast, within conversion time.
// RQ19: First conversion takes 131 to 134 states slow, 69 to 70 fast.
// RQ20: Later scan conversions take 128 states slow, 66 fast.
// RQ21: The end flag clears by a zero write only after reading one.
// RQ22: The speed bit picks slow timing at zero, fast timing at one.
// RQ23: The scan bit picks single mode at zero, scan mode at one.
// RQ24: Standby also clears the start bit and stops a scan.
// RQ25: Trial codes start at the top bit; the final code is latched.
`timescale 1ns/1ns
module sas_top
  import sas_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_trigger_pin,
  input  wire logic              standby_req,
  input  wire logic              cmp_hi,
  output logic                   conv_end_irq,
  output logic [2:0]             analog_sel,
  output logic                   sample_en,
  output logic [RES_BITS-1:0]    trial_code,
  output logic                   busy
);
  if (ADDR_W < 8)
  begin : g_chk_addr
    $error("sas_top needs at least eight address bits");
  end
  if (RES_BITS != 10 || NUM_CH != 8)
  begin : g_chk_res
    $error("sas_top serves ten bits and eight channels only");
  end
  if (STEP_SLOW * 10 >= CONV_SLOW || STEP_FAST * 10 >= CONV_FAST)
  begin : g_chk_step
    $error("bit decisions must end before the conversion phase does");
  end

  sas_csr_t            csr_q;
  sas_csr_t            csr_d;
  logic                trg_en_q;
  logic                trg_rsv0_q;
  logic                edge_sel_q;
  logic                flag_seen_q;
  logic                flag_seen_d;
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;
  logic [31:0]         rd_word;
  logic [RES_BITS-1:0] data_q [NUM_CH];
  sas_state_t          state_q;
  sas_state_t          state_d;
  logic [6:0]          cnt_q;
  logic [6:0]          cnt_d;
  logic [3:0]          sub_q;
  logic [3:0]          sub_d;
  logic [3:0]          nstep_q;
  logic [3:0]          nstep_d;
  logic [2:0]          chan_q;
  logic [2:0]          chan_d;
  logic [1:0]          prediv_q;
  logic                irq_q;
  logic                sample_q;
  logic                busy_q;
  logic                sar_load;
  logic                conv_done;
  logic                single_end;
  logic                group_end;
  logic                trig_fire;
  logic [RES_BITS-1:0] sar_code;

  // Bus decode.
  wire       acc_w     = psel & penable;
  wire       done_w    = acc_w & pready_q;
  wire       wr_w      = done_w & pwrite;
  wire       rd_w      = done_w & ~pwrite;
  wire [7:0] a8        = paddr[7:0];
  wire       hi_zero   = (paddr >> 8) == '0;
  wire       hit_csr   = hi_zero & (a8 == OFS_CSR);
  wire       hit_trg   = hi_zero & (a8 == OFS_TRG);
  wire       hit_edge  = hi_zero & (a8 == OFS_EDGE);
  wire       hit_data  = hi_zero & (a8 >= OFS_DATA0) & (a8 <= OFS_DATA_LAST) & (a8[1:0] == 2'b00);
  wire [7:0] data_off  = a8 - OFS_DATA0;
  wire [2:0] data_idx  = data_off[4:2];
  wire       mapped    = hit_csr | hit_trg | hit_edge | hit_data;
  wire       wr_csr    = wr_w & hit_csr;
  wire       wr_trg    = wr_w & hit_trg;
  wire       wr_edge   = wr_w & hit_edge;
  wire       rd_csr    = rd_w & hit_csr;

  // Reserved trigger bits 6 to 1 are constant ones, never stored; bit 0 is stored.
  wire [7:0] trg_word  = {trg_en_q, 6'b0, trg_rsv0_q} | TRG_RSVD_ONES; // [RQ7]

  assign rd_word = hit_csr  ? {24'h000000, csr_q} :
                   hit_trg  ? {24'h000000, trg_word} :
                   hit_edge ? {31'h00000000, edge_sel_q} :
                   hit_data ? {22'h000000, data_q[data_idx]} :
                   32'h00000000;

  // Read data is captured a cycle ahead, so pready can come from a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= acc_w & ~pready_q;
      pslverr_q <= acc_w & ~pready_q & ~mapped;
      if (acc_w & ~pready_q & ~pwrite)
        prdata_q <= rd_word;
    end
  end

  // Trigger and edge select registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trg_en_q   <= TRG_EN_RST; // [RQ4]
      trg_rsv0_q <= TRG_RSV0_RST;
      edge_sel_q <= EDGE_SEL_RST; // [RQ5]
    end
    else
    begin
      if (wr_trg)
      begin
        trg_en_q   <= pwdata[TRG_EN_POS];
        trg_rsv0_q <= pwdata[TRG_RSV0_POS]; // [RQ8]
      end
      if (wr_edge)
        edge_sel_q <= pwdata[EDGE_SEL_POS];
    end
  end

  sas_trig u_trig (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      (ext_trigger_pin),
    .enable   (trg_en_q), // [RQ4]
    .rise_sel (edge_sel_q), // [RQ5]
    .fire     (trig_fire)
  );

  // Control and status register; a flag set beats a clear in the same cycle.
  wire flag_clr = wr_csr & ~pwdata[CSR_FLAG_POS] & flag_seen_q; // [RQ21]
  wire flag_set = single_end | group_end; // [RQ13] [RQ15]

  always_comb
  begin
    csr_d = csr_q;
    if (single_end)
      csr_d.start = 1'b0; // [RQ14]
    if (wr_csr)
    begin
      csr_d.irq_en = pwdata[CSR_IRQ_POS];
      csr_d.start  = pwdata[CSR_START_POS]; // [RQ10]
      csr_d.scan   = pwdata[CSR_SCAN_POS]; // [RQ23]
      csr_d.speed  = pwdata[CSR_SPEED_POS]; // [RQ22]
      csr_d.chan   = pwdata[2:0];
    end
    if (trig_fire)
      csr_d.start = 1'b1; // [RQ5] [RQ6]
    if (standby_req)
      csr_d.start = 1'b0; // [RQ24]
    if (flag_clr)
      csr_d.end_flag = 1'b0; // [RQ21]
    if (flag_set)
      csr_d.end_flag = 1'b1; // [RQ13] [RQ15]
  end

  assign flag_seen_d = (flag_seen_q | (rd_csr & csr_q.end_flag)) & ~flag_clr; // [RQ21]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      csr_q       <= CSR_RST;
      flag_seen_q <= 1'b0;
    end
    else
    begin
      csr_q       <= csr_d;
      flag_seen_q <= flag_seen_d;
    end
  end

  // Timing selection; the free-running phase makes the start delay depend
  // on when the start lands, as with a prescaled converter clock.
  wire        fast     = csr_q.speed; // [RQ22]
  wire [6:0]  phase_w  = fast ? {6'h00, prediv_q[0]} : {5'h00, prediv_q};
  wire [6:0]  dly_w    = sas_pick(fast, DLY_SLOW_MIN, DLY_FAST_MIN) + phase_w; // [RQ17]
  wire [6:0]  spl_w    = sas_pick(fast, SPL_SLOW, SPL_FAST); // [RQ18]
  wire [6:0]  conv_w   = sas_pick(fast, CONV_SLOW, CONV_FAST); // [RQ19]
  wire [6:0]  gap_w    = sas_pick(fast, GAP_SLOW, GAP_FAST); // [RQ20]
  wire [3:0]  step_len = fast ? STEP_FAST : STEP_SLOW;
  wire        sar_step = (state_q == SAS_CONV) & (sub_q == step_len - 4'h1) & (nstep_q < 4'hA); // [RQ11]
  wire [2:0]  first_ch = sas_first(csr_q.scan, csr_q.chan); // [RQ1] [RQ3]
  wire        last_ch  = chan_q == csr_q.chan; // [RQ2]
  wire        run      = csr_q.start;

  // Sequencer.
  always_comb
  begin
    state_d    = state_q;
    cnt_d      = (cnt_q == 7'h00) ? 7'h00 : cnt_q - 7'h01;
    sub_d      = sub_q;
    nstep_d    = nstep_q;
    chan_d     = chan_q;
    sar_load   = 1'b0;
    conv_done  = 1'b0;
    single_end = 1'b0;
    group_end  = 1'b0;
    case (state_q)
      SAS_IDLE:
      begin
        if (run)
        begin
          state_d = SAS_DELAY;
          cnt_d   = dly_w - 7'h02; // [RQ17]
          chan_d  = first_ch; // [RQ1] [RQ3]
        end
      end
      SAS_DELAY:
      begin
        if (!run)
          state_d = SAS_IDLE;
        else if (cnt_q == 7'h00)
        begin
          state_d = SAS_SAMPLE;
          cnt_d   = spl_w - 7'h01; // [RQ18]
        end
      end
      SAS_SAMPLE:
      begin
        if (!run)
          state_d = SAS_IDLE;
        else if (cnt_q == 7'h00)
        begin
          state_d  = SAS_CONV;
          cnt_d    = conv_w - 7'h01; // [RQ19]
          sub_d    = 4'h0;
          nstep_d  = 4'h0;
          sar_load = 1'b1; // [RQ25]
        end
      end
      SAS_CONV:
      begin
        sub_d   = sar_step ? 4'h0 : sub_q + 4'h1;
        nstep_d = sar_step ? nstep_q + 4'h1 : nstep_q;
        if (!run)
          state_d = SAS_IDLE; // [RQ16]
        else if (cnt_q == 7'h00)
        begin
          conv_done = 1'b1; // [RQ12]
          if (!csr_q.scan)
          begin
            state_d    = SAS_IDLE; // [RQ14]
            single_end = 1'b1; // [RQ13]
          end
          else
          begin
            state_d = SAS_GAP; // [RQ20]
            cnt_d   = gap_w - 7'h01;
            if (last_ch)
            begin
              group_end = 1'b1; // [RQ15]
              chan_d    = first_ch; // [RQ15]
            end
            else
              chan_d = chan_q + 3'h1; // [RQ2]
          end
        end
      end
      SAS_GAP:
      begin
        if (!run)
          state_d = SAS_IDLE; // [RQ16]
        else if (cnt_q == 7'h00)
        begin
          state_d = SAS_SAMPLE;
          cnt_d   = spl_w - 7'h01; // [RQ18]
        end
      end
      default:
        state_d = SAS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= SAS_IDLE;
      cnt_q    <= 7'h00;
      sub_q    <= 4'h0;
      nstep_q  <= 4'h0;
      chan_q   <= 3'h0;
      prediv_q <= 2'h0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sub_q    <= sub_d;
      nstep_q  <= nstep_d;
      chan_q   <= chan_d;
      prediv_q <= prediv_q + 2'h1;
    end
  end

  sas_sar #(
    .W (RES_BITS)
  ) u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (sar_load), // [RQ25]
    .step    (sar_step), // [RQ11]
    .keep    (cmp_hi),
    .code    (sar_code)
  );

  // Result registers, one per input.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CH; i++)
        data_q[i] <= '0;
    end
    else if (conv_done)
      data_q[chan_q] <= sar_code; // [RQ12] [RQ25]
  end

  // Output flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q    <= 1'b0;
      sample_q <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      irq_q    <= csr_d.end_flag & csr_d.irq_en; // [RQ13] [RQ15]
      sample_q <= state_d == SAS_SAMPLE; // [RQ18]
      busy_q   <= state_d != SAS_IDLE;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign conv_end_irq = irq_q;
  assign analog_sel   = chan_q;
  assign sample_en    = sample_q;
  assign trial_code   = sar_code;
  assign busy         = busy_q;
endmodule : sas_top

// *** sas_top_monitor.sv ***
// Purpose: Port-level assertions for the converter sequencer.
// Assumes: One converter state per pclk cycle; standby pulses are short.
// Notes:   Period and sample counters restart whenever the sequencer idles.
`timescale 1ns/1ns
module sas_top_monitor
  import sas_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              ext_trigger_pin,
  input wire logic              standby_req,
  input wire logic              cmp_hi,
  input wire logic              conv_end_irq,
  input wire logic [2:0]        analog_sel,
  input wire logic              sample_en,
  input wire logic [RES_BITS-1:0] trial_code,
  input wire logic              busy
);
  logic       samp_q;
  logic [7:0] spl_q;
  logic [7:0] per_q;
  wire        rise    = sample_en & ~samp_q;
  wire        fall    = ~sample_en & samp_q & busy;
  wire        wr_done = psel & penable & pready & pwrite;
  wire [7:0]  spl_d   = sample_en ? spl_q + 8'h01 : 8'h00;
  // Only periods wholly inside one run count, so an idle cycle clears the tally.
  wire [7:0]  per_d   = !busy ? 8'h00 : (rise ? 8'h01 : (per_q != 8'h00 ? per_q + 8'h01 : 8'h00));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      samp_q <= 1'b0;
      spl_q  <= 8'h00;
      per_q  <= 8'h00;
    end
    else
    begin
      samp_q <= sample_en;
      spl_q  <= spl_d;
      per_q  <= per_d;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sample_len: assert property (
    fall |-> (spl_q == 8'h1F) || (spl_q == 8'h0F)) else $error("sampling phase has wrong length");
  a_scan_period: assert property (
    rise && per_q != 8'h00 |-> (per_q == 8'h80) || (per_q == 8'h42)) else $error("scan repeat period wrong");
  a_trial_msb: assert property (
    fall |-> ##[0:1] trial_code == 10'h200) else $error("first trial code is not the top bit");
  a_irq_cause: assert property (
    $rose(conv_end_irq) |-> $past(busy) || $past(wr_done)) else $error("irq rose without a conversion end");
  a_irq_drop: assert property (
    $fell(conv_end_irq) |-> $past(wr_done)) else $error("irq fell without a register write");
  a_standby_stop: assert property (
    standby_req |-> ##[1:3] !busy) else $error("standby did not stop the sequencer");
  a_sel_stable: assert property (
    sample_en && samp_q |-> $stable(analog_sel)) else $error("input changed while sampling");
  a_sample_in_run: assert property (
    sample_en |-> busy) else $error("sampling outside a conversion");

  c_irq: cover property ($rose(conv_end_irq));
  c_scan: cover property (rise && per_q != 8'h00);
  c_standby: cover property (standby_req && busy);
endmodule : sas_top_monitor

bind sas_top sas_top_monitor #(.ADDR_W(ADDR_W)) u_sas_top_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_trigger_pin, .standby_req, .cmp_hi, .conv_end_irq,
  .analog_sel, .sample_en, .trial_code, .busy);

// *** test_sar_adc_sequencer.sv ***
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: The comparator model answers from a per-input target table.
// Notes:   Results must equal the targets, so a wrong bit order shows up.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module test_sar_adc_sequencer;
  import sas_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic        ext_trigger_pin, standby_req, cmp_hi, conv_end_irq, sample_en, busy, sp, err;
  logic [2:0]  analog_sel, cs;
  logic [9:0]  trial_code;
  logic [9:0]  tgt [8];
  int          num_errors, num_checks, cyc, n, k;

  sas_top u_sas_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trigger_pin(ext_trigger_pin), .standby_req(standby_req), .cmp_hi(cmp_hi),
    .conv_end_irq(conv_end_irq), .analog_sel(analog_sel), .sample_en(sample_en),
    .trial_code(trial_code), .busy(busy));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Start delay jitter is allowed only on the first conversion of a run.
  function automatic logic ok_time(input int t, input logic f, input int cnt);
    int lo;
    lo = (f ? 69 : 131) + (cnt - 1) * (f ? 66 : 128);
    ok_time = (t >= lo) && (t <= lo + (f ? 1 : 3));
  endfunction : ok_time

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    j = 0;
    do
    begin
      @(posedge pclk);
      j++;
    end
    while (pready !== 1'b1 && j < 20);
    if (j == 20)
      num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask : rchk

  task automatic wait_irq;
    n = 0;
    // Step past the edge first, so a flag cleared at that edge is not taken as still set.
    #1;
    while (conv_end_irq !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : wait_irq

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk)
    cmp_hi <= (tgt[analog_sel] >= trial_code);

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      finish_test();
    end
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, standby_req, presetn} = '0;
    ext_trigger_pin = 1'b1;
    rnd = 32'h482096AE;
    foreach (tgt[i]) tgt[i] = 10'h000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("csr reset", OFS_CSR, 32'h00);
    apb(1'b1, OFS_TRG, 32'h00);
    rchk("trg reserved", OFS_TRG, 32'h7E);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    for (int ch = 0; ch < 8; ch++)
    begin
      sp = ch[0];
      rnd = lfsr(rnd);
      tgt[ch] = (ch == 0) ? 10'h000 : ((ch == 7) ? 10'h3FF : rnd[9:0]);
      apb(1'b1, OFS_CSR, {24'h0, 4'b0110, sp, ch[2:0]});
      wait_irq();
      `CHK("single time", 1'b1, ok_time(n, sp, 1))
      apb(1'b1, OFS_CSR, {24'h0, 4'b0100, sp, ch[2:0]});
      rchk("single end", OFS_CSR, {24'h0, 4'b1100, sp, ch[2:0]});
      apb(1'b1, OFS_CSR, 32'h0);
      rchk("flag clear", OFS_CSR, 32'h0);
      rchk("single data", OFS_DATA0 + 8'(4 * ch), {22'h0, tgt[ch]});
    end
    for (int i = 0; i < 2; i++)
    begin
      sp = (i == 0);
      cs = sp ? 3'b110 : 3'b011;
      k = cs[1:0] + 1;
      for (int c = 0; c < 8; c++)
      begin
        rnd = lfsr(rnd);
        tgt[c] = rnd[9:0];
      end
      apb(1'b1, OFS_CSR, {24'h0, 4'b0111, sp, cs});
      wait_irq();
      `CHK("scan time", 1'b1, ok_time(n, sp, k))
      rchk("scan csr", OFS_CSR, {24'h0, 4'b1111, sp, cs});
      for (int c = 0; c < k; c++)
        rchk("scan data", OFS_DATA0 + 8'(4 * ({cs[2], 2'b00} + c)), {22'h0, tgt[{cs[2], 2'b00} + c]});
      apb(1'b1, OFS_CSR, {24'h0, 4'b0111, sp, cs});
      wait_irq();
      `CHK("scan repeat", 1'b1, n <= k * (sp ? 66 : 128))
      apb(1'b1, OFS_CSR, 32'h0);
      rchk("scan stop", OFS_CSR, 32'h80);
      apb(1'b1, OFS_CSR, 32'h0);
      `CHK("scan idle", 1'b0, busy)
    end
    apb(1'b1, OFS_TRG, 32'h80);
    rchk("trg enable", OFS_TRG, 32'hFE);
    for (int e = 0; e < 2; e++)
    begin
      rnd = lfsr(rnd);
      tgt[5 + e] = rnd[9:0];
      apb(1'b1, OFS_EDGE, 32'(e));
      apb(1'b1, OFS_CSR, 32'h45 + 32'(e));
      ext_trigger_pin <= e[0];
      wait_irq();
      `CHK("trigger time", 1'b1, ok_time(n - 2, 1'b0, 1))
      rchk("trigger csr", OFS_CSR, 32'hC5 + 32'(e));
      apb(1'b1, OFS_CSR, 32'h0);
      rchk("trigger data", OFS_DATA0 + 8'(4 * (5 + e)), {22'h0, tgt[5 + e]});
    end
    apb(1'b1, OFS_TRG, 32'h00);
    ext_trigger_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_trigger_pin <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK("trigger off", 1'b0, busy)
    apb(1'b1, OFS_CSR, 32'h20);
    repeat (50) @(posedge pclk);
    standby_req <= 1'b1;
    @(posedge pclk);
    standby_req <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("standby idle", 1'b0, busy)
    rchk("standby csr", OFS_CSR, 32'h00);
    finish_test();
  end
endmodule : test_sar_adc_sequencer
